/* lcdp_pkg.sv */
`default_nettype none
package lcdp_pkg;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CONFIG_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] MASK_OFFSET = 8'h0c;
  localparam logic [7:0] CHAN1_BASE_OFFSET = 8'h10;
  localparam logic [7:0] CHAN1_CUR_OFFSET = 8'h14;
  localparam logic [7:0] CHAN2_BASE_OFFSET = 8'h18;
  localparam logic [7:0] CHAN2_CUR_OFFSET = 8'h1c;

  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_DUAL_BIT = 1;
  localparam int CTRL_MONO_BIT = 2;
  localparam int CTRL_DOUBLE_BIT = 3;
  localparam int CTRL_WIDTH = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  localparam int PIXELS_LSB = 0;
  localparam int LINES_LSB = 16;
  localparam int LINE_FIELD_WIDTH = 10;
  localparam logic [9:0] PIXELS_RESET = 10'h000;
  localparam logic [9:0] LINES_RESET = 10'h000;

  localparam int STATUS_UPDATE_BIT = 0;
  localparam int STATUS_BERR_BIT = 1;
  localparam int STATUS_WIDTH = 2;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;

  localparam int PIXEL_SIZE_LSB = 12;
  localparam logic [1:0] PIXEL_SIZE_RESET = 2'h0;
  localparam logic [31:0] PALETTE_BYTES_SMALL = 32'h20;
  localparam logic [31:0] PALETTE_BYTES_LARGE = 32'h200;

  localparam logic [31:0] WORD_BYTES = 32'h4;
  localparam logic [2:0] BURST_WORDS = 3'h4;
  localparam logic [3:0] BURST_SPACE = 4'h4;

  typedef enum logic [1:0] {
    BURST_IDLE,
    BURST_REQ,
    BURST_DATA
  } lcdp_burst_type;
endpackage : lcdp_pkg
`default_nettype wire

/* lcdp_end_calc.sv */
`default_nettype none
module lcdp_end_calc (
  input wire logic [9:0] pixels_per_line,
  input wire logic [9:0] lines_per_panel,
  input wire logic color_mono_select,
  input wire logic double_pixel_data,
  input wire logic [1:0] pixel_bit_size,
  output logic [31:0] frame_bytes,
  output logic [31:0] palette_bytes
);
  logic [20:0] pixels;
  logic [31:0] raw_bytes;
  logic [31:0] sized_bytes;

  // Fields hold count minus one
  assign pixels = ({11'h000, pixels_per_line} + 21'h000001) *
                  ({11'h000, lines_per_panel} + 21'h000001);

  always_comb begin
    case (pixel_bit_size)
      2'h0: raw_bytes = {12'h000, pixels[20:1]};
      2'h1: raw_bytes = {11'h000, pixels};
      default: raw_bytes = {10'h000, pixels, 1'b0};
    endcase
  end

  // Monochrome panels with double pixel data take twice the data
  assign sized_bytes = (color_mono_select && double_pixel_data) ?
                       {raw_bytes[30:0], 1'b0} : raw_bytes;
  // Rounded up to whole bursts
  assign frame_bytes = (sized_bytes + 32'hf) & 32'hffff_fff0;
  assign palette_bytes = (pixel_bit_size == 2'h0) ? lcdp_pkg::PALETTE_BYTES_SMALL
                                                  : lcdp_pkg::PALETTE_BYTES_LARGE;
endmodule : lcdp_end_calc
`default_nettype wire

/* lcdp_chan.sv */
`default_nettype none
module lcdp_chan (
  input wire logic pclk,
  input wire logic ce,
  input wire logic active,
  input wire logic enable_rise,
  input wire logic [31:0] base_pointer,
  input wire logic [31:0] end_addr,
  input wire logic word_done,
  output logic [31:0] current_pointer,
  output logic reload
);
  assign reload = ce && (enable_rise || (active && current_pointer == end_addr));

  // No reset: contents stay unknown until the first enable loads them
  always_ff @(posedge pclk) begin
    if (reload) begin
      current_pointer <= base_pointer;
    end else if (ce && word_done) begin
      current_pointer <= current_pointer + lcdp_pkg::WORD_BYTES;
    end
  end
endmodule : lcdp_chan
`default_nettype wire

/* lcdp_dma_top.sv */
`default_nettype none
module lcdp_dma_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic mem_req,
  input wire logic mem_ack,
  output logic [31:0] mem_addr,
  output logic mem_chan,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_berr,
  input wire logic [3:0] fifo1_space,
  input wire logic [3:0] fifo2_space,
  output logic fifo1_wvalid,
  output logic fifo2_wvalid,
  output logic palette_wvalid,
  output logic [31:0] fifo_wdata
);
  logic [3:0] ctrl;
  logic [9:0] pixels_per_line;
  logic [9:0] lines_per_panel;
  logic [1:0] status;
  logic [1:0] mask;
  logic [31:0] chan1_base_pointer;
  logic [31:0] chan2_base_pointer;
  logic [31:0] chan1_current_pointer;
  logic [31:0] chan2_current_pointer;
  logic [1:0] pixel_bit_size;
  logic display_enable;
  logic dual_screen_select;
  logic color_mono_select;
  logic double_pixel_data;
  logic enable_prev;
  logic enable_rise;
  logic chan1_active;
  logic chan2_active;
  logic [31:0] frame_bytes;
  logic [31:0] palette_bytes;
  logic [31:0] chan1_end;
  logic [31:0] chan2_end;
  logic chan1_reload;
  logic chan2_reload;
  logic chan1_word;
  logic chan2_word;
  logic reload1_seen;
  logic reload2_seen;
  logic update_set;
  logic update_clear;
  logic berr_set;
  logic size_pending;
  logic in_palette;
  logic setup;
  logic access_wr;
  logic addr_ok;
  logic [31:0] next_prdata;
  lcdp_pkg::lcdp_burst_type state;
  lcdp_pkg::lcdp_burst_type next_state;
  logic [2:0] word_count;
  logic next_chan;

  assign display_enable = ctrl[lcdp_pkg::CTRL_ENABLE_BIT];
  assign dual_screen_select = ctrl[lcdp_pkg::CTRL_DUAL_BIT];
  assign color_mono_select = ctrl[lcdp_pkg::CTRL_MONO_BIT];
  assign double_pixel_data = ctrl[lcdp_pkg::CTRL_DOUBLE_BIT];

  assign chan1_active = display_enable;
  assign chan2_active = display_enable && dual_screen_select;
  assign enable_rise = display_enable && !enable_prev;

  // APB slave: zero wait states, read data captured in the setup cycle
  assign setup = psel && !penable;
  assign access_wr = ce && psel && penable && pwrite;
  assign pready = 1'b1;

  always_comb begin
    addr_ok = 1'b1;
    case (paddr)
      lcdp_pkg::CTRL_OFFSET,
      lcdp_pkg::CONFIG_OFFSET,
      lcdp_pkg::STATUS_OFFSET,
      lcdp_pkg::MASK_OFFSET,
      lcdp_pkg::CHAN1_BASE_OFFSET,
      lcdp_pkg::CHAN1_CUR_OFFSET,
      lcdp_pkg::CHAN2_BASE_OFFSET,
      lcdp_pkg::CHAN2_CUR_OFFSET: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_ok;

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      lcdp_pkg::CTRL_OFFSET: next_prdata = {28'h000_0000, ctrl};
      lcdp_pkg::CONFIG_OFFSET: begin
        next_prdata[lcdp_pkg::PIXELS_LSB +: lcdp_pkg::LINE_FIELD_WIDTH] = pixels_per_line;
        next_prdata[lcdp_pkg::LINES_LSB +: lcdp_pkg::LINE_FIELD_WIDTH] = lines_per_panel;
      end
      lcdp_pkg::STATUS_OFFSET: next_prdata = {30'h0000_0000, status};
      lcdp_pkg::MASK_OFFSET: next_prdata = {30'h0000_0000, mask};
      lcdp_pkg::CHAN1_BASE_OFFSET: next_prdata = chan1_base_pointer;
      lcdp_pkg::CHAN1_CUR_OFFSET: next_prdata = chan1_current_pointer;
      lcdp_pkg::CHAN2_BASE_OFFSET: next_prdata = chan2_base_pointer;
      lcdp_pkg::CHAN2_CUR_OFFSET: next_prdata = chan2_current_pointer;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && setup && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= lcdp_pkg::CTRL_RESET;
      pixels_per_line <= lcdp_pkg::PIXELS_RESET;
      lines_per_panel <= lcdp_pkg::LINES_RESET;
      mask <= lcdp_pkg::MASK_RESET;
    end else if (access_wr) begin
      case (paddr)
        lcdp_pkg::CTRL_OFFSET: ctrl <= pwdata[lcdp_pkg::CTRL_WIDTH-1:0];
        lcdp_pkg::CONFIG_OFFSET: begin
          pixels_per_line <= pwdata[lcdp_pkg::PIXELS_LSB +: lcdp_pkg::LINE_FIELD_WIDTH];
          lines_per_panel <= pwdata[lcdp_pkg::LINES_LSB +: lcdp_pkg::LINE_FIELD_WIDTH];
        end
        lcdp_pkg::MASK_OFFSET: mask <= pwdata[lcdp_pkg::STATUS_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // Base pointers are not reset; writes to current pointer offsets fall through
  always_ff @(posedge pclk) begin
    if (access_wr && paddr == lcdp_pkg::CHAN1_BASE_OFFSET) begin
      chan1_base_pointer <= pwdata;
    end
    if (access_wr && paddr == lcdp_pkg::CHAN2_BASE_OFFSET) begin
      chan2_base_pointer <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_prev <= 1'b0;
    end else if (ce) begin
      enable_prev <= display_enable;
    end
  end

  lcdp_end_calc u_end_calc (
    .pixels_per_line(pixels_per_line),
    .lines_per_panel(lines_per_panel),
    .color_mono_select(color_mono_select),
    .double_pixel_data(double_pixel_data),
    .pixel_bit_size(pixel_bit_size),
    .frame_bytes(frame_bytes),
    .palette_bytes(palette_bytes)
  );

  // Only channel 1 carries the palette ahead of its pixels
  assign chan1_end = chan1_base_pointer + palette_bytes + frame_bytes;
  assign chan2_end = chan2_base_pointer + frame_bytes;

  lcdp_chan u_chan1 (
    .pclk(pclk),
    .ce(ce),
    .active(chan1_active),
    .enable_rise(enable_rise),
    .base_pointer(chan1_base_pointer),
    .end_addr(chan1_end),
    .word_done(chan1_word),
    .current_pointer(chan1_current_pointer),
    .reload(chan1_reload)
  );

  lcdp_chan u_chan2 (
    .pclk(pclk),
    .ce(ce),
    .active(chan2_active),
    .enable_rise(enable_rise),
    .base_pointer(chan2_base_pointer),
    .end_addr(chan2_end),
    .word_done(chan2_word),
    .current_pointer(chan2_current_pointer),
    .reload(chan2_reload)
  );

  // Burst engine: one 4-word burst at a time, channel 1 first
  always_comb begin
    next_state = state;
    case (state)
      lcdp_pkg::BURST_IDLE: begin
        if (chan1_active && fifo1_space >= lcdp_pkg::BURST_SPACE) begin
          next_state = lcdp_pkg::BURST_REQ;
        end else if (chan2_active && fifo2_space >= lcdp_pkg::BURST_SPACE) begin
          next_state = lcdp_pkg::BURST_REQ;
        end
      end
      lcdp_pkg::BURST_REQ: begin
        if (mem_ack) begin
          next_state = lcdp_pkg::BURST_DATA;
        end
      end
      lcdp_pkg::BURST_DATA: begin
        if (mem_rvalid && word_count == lcdp_pkg::BURST_WORDS - 3'h1) begin
          next_state = lcdp_pkg::BURST_IDLE;
        end
      end
      default: next_state = lcdp_pkg::BURST_IDLE;
    endcase
  end

  assign next_chan = !(chan1_active && fifo1_space >= lcdp_pkg::BURST_SPACE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= lcdp_pkg::BURST_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr <= 32'h0000_0000;
      mem_chan <= 1'b0;
    end else if (ce && state == lcdp_pkg::BURST_IDLE &&
                 next_state == lcdp_pkg::BURST_REQ) begin
      mem_chan <= next_chan;
      mem_addr <= next_chan ? chan2_current_pointer : chan1_current_pointer;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_count <= 3'h0;
    end else if (ce) begin
      if (state != lcdp_pkg::BURST_DATA) begin
        word_count <= 3'h0;
      end else if (mem_rvalid) begin
        word_count <= word_count + 3'h1;
      end
    end
  end

  assign mem_req = (state == lcdp_pkg::BURST_REQ);
  assign chan1_word = (state == lcdp_pkg::BURST_DATA) && mem_rvalid && !mem_chan;
  assign chan2_word = (state == lcdp_pkg::BURST_DATA) && mem_rvalid && mem_chan;

  // Leading palette region of channel 1 goes to the palette, never from channel 2
  assign in_palette = (chan1_current_pointer - chan1_base_pointer) < palette_bytes;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo1_wvalid <= 1'b0;
      fifo2_wvalid <= 1'b0;
      palette_wvalid <= 1'b0;
      fifo_wdata <= 32'h0000_0000;
    end else if (ce) begin
      palette_wvalid <= chan1_word && in_palette;
      fifo1_wvalid <= chan1_word && !in_palette;
      fifo2_wvalid <= chan2_word;
      if (chan1_word || chan2_word) begin
        fifo_wdata <= mem_rdata;
      end
    end
  end

  // Pixel size comes from the first palette entry of each channel 1 frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      size_pending <= 1'b0;
      pixel_bit_size <= lcdp_pkg::PIXEL_SIZE_RESET;
    end else if (ce) begin
      if (chan1_reload) begin
        size_pending <= 1'b1;
      end else if (chan1_word && size_pending) begin
        size_pending <= 1'b0;
        pixel_bit_size <= mem_rdata[lcdp_pkg::PIXEL_SIZE_LSB +: 2];
      end
    end
  end

  // Dual mode waits for both channels to reload before flagging
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload1_seen <= 1'b0;
      reload2_seen <= 1'b0;
    end else if (ce) begin
      if (update_set || !dual_screen_select) begin
        reload1_seen <= 1'b0;
        reload2_seen <= 1'b0;
      end else begin
        reload1_seen <= reload1_seen || chan1_reload;
        reload2_seen <= reload2_seen || chan2_reload;
      end
    end
  end

  assign update_set = dual_screen_select ?
                      ((reload1_seen || chan1_reload) && (reload2_seen || chan2_reload)) :
                      chan1_reload;
  assign update_clear = access_wr && (
                        (paddr == (dual_screen_select ? lcdp_pkg::CHAN2_BASE_OFFSET
                                                      : lcdp_pkg::CHAN1_BASE_OFFSET)) ||
                        (paddr == lcdp_pkg::STATUS_OFFSET &&
                         pwdata[lcdp_pkg::STATUS_UPDATE_BIT]));
  assign berr_set = ce && (chan1_word || chan2_word) && mem_berr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= lcdp_pkg::STATUS_RESET;
    end else if (ce) begin
      if (update_set) begin
        status[lcdp_pkg::STATUS_UPDATE_BIT] <= 1'b1;
      end else if (update_clear) begin
        status[lcdp_pkg::STATUS_UPDATE_BIT] <= 1'b0;
      end
      if (berr_set) begin
        status[lcdp_pkg::STATUS_BERR_BIT] <= 1'b1;
      end else if (access_wr && paddr == lcdp_pkg::STATUS_OFFSET &&
                   pwdata[lcdp_pkg::STATUS_BERR_BIT]) begin
        status[lcdp_pkg::STATUS_BERR_BIT] <= 1'b0;
      end
    end
  end

  assign irq = |(status & mask);
endmodule : lcdp_dma_top
`default_nettype wire

/* lcdp_dma_top_props.sv */
`default_nettype none
module lcdp_dma_top_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_addr,
  input wire logic mem_chan,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_berr,
  input wire logic [3:0] fifo1_space,
  input wire logic [3:0] fifo2_space,
  input wire logic fifo1_wvalid,
  input wire logic fifo2_wvalid,
  input wire logic palette_wvalid,
  input wire logic [31:0] fifo_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wcnt;
  logic wv;
  assign wv = fifo1_wvalid | fifo2_wvalid | palette_wvalid;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Words delivered since the last accepted burst
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wcnt <= 3'h4;
    else if (mem_req && mem_ack) wcnt <= 3'h0;
    else if (wv) wcnt <= wcnt + 3'h1;
  end
  a_burst_gap: assert property (mem_req && mem_ack |=> !mem_req [*5])
    else $error("burst request too soon");
  a_addr_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("request dropped or moved before accept");
  a_req_space: assert property ($rose(mem_req) |->
    ($past(fifo1_space) >= 4'h4 || $past(fifo2_space) >= 4'h4))
    else $error("burst without four free entries");
  a_chan_pick: assert property ($rose(mem_req) |-> (mem_chan ?
    ($past(fifo1_space) < 4'h4 && $past(fifo2_space) >= 4'h4) :
    $past(fifo1_space) >= 4'h4))
    else $error("wrong channel chosen");
  a_four_words: assert property (mem_req && mem_ack |-> wcnt == 3'h4)
    else $error("burst did not deliver four words");
  a_word_pass: assert property (ce && mem_rvalid |=> wv && fifo_wdata == $past(mem_rdata))
    else $error("word not forwarded");
  a_one_sink: assert property ($onehot0({fifo1_wvalid, fifo2_wvalid, palette_wvalid}))
    else $error("word sent to two sinks");
  a_chan2_pal: assert property (mem_req && mem_ack && mem_chan |=>
    (!palette_wvalid && !fifo1_wvalid) [*5])
    else $error("lower channel word left its queue");
  a_apb_err: assert property (psel && penable && paddr[1:0] == 2'h0 |->
    pslverr == (paddr >= 8'h20))
    else $error("error response wrong");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  c_dual: cover property (mem_req && mem_ack && mem_chan);
  c_pal: cover property (palette_wvalid);
  c_berr: cover property (mem_rvalid && mem_berr);
  c_irq: cover property ($rose(irq));
endmodule : lcdp_dma_top_props
bind lcdp_dma_top lcdp_dma_top_props i_lcdp_dma_top_props (
  .pclk, .presetn, .ce, .psel, .penable, .paddr, .pslverr, .irq, .mem_req, .mem_ack,
  .mem_addr, .mem_chan, .mem_rvalid, .mem_rdata, .mem_berr, .fifo1_space, .fifo2_space,
  .fifo1_wvalid, .fifo2_wvalid, .palette_wvalid, .fifo_wdata
);
`default_nettype wire

/* lcdp_mem_model.sv */
`default_nettype none
module lcdp_mem_model (
  input wire logic pclk,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic slow,
  input wire logic berr_on,
  output logic mem_ack,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata,
  output logic mem_berr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] addr;
  initial begin
    mem_ack = 1'b0;
    mem_rvalid = 1'b0;
    mem_rdata = 32'h5a5a_a5a5;
    mem_berr = 1'b0;
    forever begin
      @(posedge pclk);
      if (mem_req === 1'b1) begin
        if (slow) repeat (3) @(posedge pclk);
        addr = mem_addr;
        mem_ack <= 1'b1;
        @(posedge pclk);
        mem_ack <= 1'b0;
        for (int k = 0; k < 4; k++) begin
          mem_rvalid <= 1'b1;
          mem_berr <= berr_on;
          // Faulted reads return zeros; lower buffer holds pixels only
          mem_rdata <= berr_on ? 32'h0 : addr + 32'(4 * k);
          @(posedge pclk);
          if (slow) begin
            mem_rvalid <= 1'b0;
            mem_berr <= 1'b0;
            mem_rdata <= ~mem_rdata;
            @(posedge pclk);
          end
        end
        if (!slow) begin
          mem_rvalid <= 1'b0;
          mem_berr <= 1'b0;
          mem_rdata <= ~mem_rdata;
        end
      end
    end
  end
endmodule : lcdp_mem_model
`default_nettype wire

/* tb_top.sv */
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("Error at %0t: got %h want %h", $time, (g), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, berr_on = 0, ce = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, mem_addr, mem_rdata, fifo_wdata, rnd;
  logic pready, pslverr, irq, mem_req, mem_ack, mem_chan, mem_rvalid, mem_berr;
  logic fifo1_wvalid, fifo2_wvalid, palette_wvalid;
  logic [3:0] fifo1_space = 4'h0, fifo2_space = 4'h0;
  logic [34:0] exp_q[$], e;
  logic [32:0] rd_q[$], re;
  int err_total = 0, total_checks = 0, acks = 0, seed = 87;
  always #4 pclk = ~pclk;
  lcdp_dma_top i_lcdp_dma_top (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .mem_req, .mem_ack, .mem_addr, .mem_chan,
    .mem_rvalid, .mem_rdata, .mem_berr, .fifo1_space, .fifo2_space, .fifo1_wvalid,
    .fifo2_wvalid, .palette_wvalid, .fifo_wdata);
  lcdp_mem_model i_lcdp_mem_model (.pclk, .mem_req, .mem_addr, .slow, .berr_on, .mem_ack,
    .mem_rvalid, .mem_rdata, .mem_berr);
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic bad(input string m);
    err_total++;
    $display("Error at %0t: %s", $time, m);
    end_of_test();
  endtask : bad
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] x);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) rd_q.push_back(x);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad("no ready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    apb(1'b0, a, 32'h0, x);
  endtask : rd
  task automatic chk_irq(input logic v);
    @(negedge pclk);
    `CHK(irq, v)
  endtask : chk_irq
  // Let n bursts start, close the queues, then wait for every noted word
  task automatic frame(input int n);
    int a0, c;
    a0 = acks;
    c = 0;
    while (acks < a0 + n && c < 3000) begin @(posedge pclk); c++; end
    fifo1_space <= 4'h0;
    fifo2_space <= 4'h0;
    while (exp_q.size() != 0 && c < 3000) begin @(posedge pclk); c++; end
    if (c >= 3000) bad("burst timeout");
    repeat (4) @(posedge pclk);
  endtask : frame
  always @(posedge pclk) if (mem_req && mem_ack) acks <= acks + 1;
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (rd_q.size() == 0) bad("stray read");
      re = rd_q.pop_front();
      `CHK({pslverr, prdata}, re)
    end
    if (fifo1_wvalid || fifo2_wvalid || palette_wvalid) begin
      if (exp_q.size() == 0) bad("stray word");
      e = exp_q.pop_front();
      `CHK({fifo2_wvalid, fifo1_wvalid, palette_wvalid, fifo_wdata}, e)
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) rd(8'(4 * i), 33'h0);
    rd(8'h20, {1'b1, 32'h0});
    rnd = $random(seed) & 32'hffff_fff0;
    wr(lcdp_pkg::CHAN2_BASE_OFFSET, rnd);
    rd(lcdp_pkg::CHAN2_BASE_OFFSET, {1'b0, rnd});
    $display("test registers done");
    // A write while the clock enable is low must not land
    ce <= 1'b0;
    wr(lcdp_pkg::MASK_OFFSET, 32'h3);
    ce <= 1'b1;
    rd(lcdp_pkg::MASK_OFFSET, 33'h0);
    wr(lcdp_pkg::CONFIG_OFFSET, 32'h1f);
    wr(lcdp_pkg::CHAN1_BASE_OFFSET, 32'h4000);
    wr(lcdp_pkg::CTRL_OFFSET, 32'h1);
    rd(lcdp_pkg::CHAN1_CUR_OFFSET, 33'h4000);
    wr(lcdp_pkg::CHAN1_CUR_OFFSET, rnd);
    rd(lcdp_pkg::CHAN1_CUR_OFFSET, 33'h4000);
    rd(lcdp_pkg::STATUS_OFFSET, 33'h1);
    chk_irq(1'b0);
    wr(lcdp_pkg::MASK_OFFSET, 32'h1);
    chk_irq(1'b1);
    wr(lcdp_pkg::STATUS_OFFSET, 32'h1);
    rd(lcdp_pkg::STATUS_OFFSET, 33'h0);
    chk_irq(1'b0);
    for (int k = 0; k < 12; k++)
      exp_q.push_back({(k < 8) ? 3'b001 : 3'b010, 32'h4000 + 32'(4 * k)});
    @(posedge pclk);
    fifo1_space <= 4'h4;
    frame(3);
    rd(lcdp_pkg::CHAN1_CUR_OFFSET, 33'h4000);
    rd(lcdp_pkg::STATUS_OFFSET, 33'h1);
    chk_irq(1'b1);
    $display("test single panel done");
    rd(lcdp_pkg::CHAN1_CUR_OFFSET, 33'h4000);
    wr(lcdp_pkg::CTRL_OFFSET, 32'h0);
    wr(lcdp_pkg::CTRL_OFFSET, 32'he);
    wr(lcdp_pkg::CHAN1_BASE_OFFSET, 32'h4000);
    wr(lcdp_pkg::CHAN2_BASE_OFFSET, 32'h8000);
    rd(lcdp_pkg::STATUS_OFFSET, 33'h0);
    wr(lcdp_pkg::CTRL_OFFSET, 32'hf);
    rd(lcdp_pkg::CHAN2_CUR_OFFSET, 33'h8000);
    rd(lcdp_pkg::STATUS_OFFSET, 33'h1);
    wr(lcdp_pkg::STATUS_OFFSET, 32'h1);
    // Mono double-pixel doubles the lower frame to two bursts
    for (int k = 0; k < 4; k++) exp_q.push_back({3'b100, 32'h8000 + 32'(4 * k)});
    fifo2_space <= 4'h4;
    frame(1);
    rd(lcdp_pkg::CHAN2_CUR_OFFSET, 33'h8010);
    slow <= 1'b1;
    berr_on <= 1'b1;
    for (int k = 0; k < 4; k++) exp_q.push_back({3'b100, 32'h0});
    fifo2_space <= 4'h4;
    frame(1);
    rd(lcdp_pkg::CHAN2_CUR_OFFSET, 33'h8000);
    rd(lcdp_pkg::STATUS_OFFSET, 33'h2);
    chk_irq(1'b0);
    $display("test dual panel done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
